// ### logic/hadc_pkg.sv
`default_nettype none
package hadc_pkg;
   localparam logic [31:0] MEM_LIMIT     = 32'h8000_0000;
   localparam logic [31:0] PMEM1_LO      = 32'h8000_0000;
   localparam logic [31:0] PIO1_LO       = 32'hF000_0000;
   localparam logic [31:0] CADDR_LO      = 32'hF080_0000;
   localparam logic [31:0] CDATA_LO      = 32'hF0C0_0000;
   localparam logic [31:0] SPEC_LO       = 32'hF0E0_0000;
   localparam logic [31:0] PMEM2_LO      = 32'hF100_0000;
   localparam logic [31:0] RSV_LO        = 32'hF200_0000;
   localparam logic [31:0] PIO2_LO       = 32'hF800_0000;
   localparam logic [31:0] WIN_LO        = 32'hF8FF_F000;
   localparam logic [31:0] WIN_HI        = 32'hF8FF_F0FF;
   localparam logic [31:0] PMEM3_LO      = 32'hF900_0000;
   localparam logic [31:0] ROM_LO        = 32'hFF00_0000;
   localparam logic [31:0] IDX_ADDR_CONT = 32'h8000_0CF8;
   localparam logic [31:0] IDX_DATA_CONT = 32'h8000_0CFC;
   localparam logic [31:0] IDX_ADDR_DISC = 32'h8006_7018;
   localparam logic [31:0] IDX_DATA_DISC = 32'h8006_701C;
   localparam logic [31:0] EXT_PORT0     = 32'h8000_0092;
   localparam logic [31:0] EXT_PORT1     = 32'h8000_081C;
   localparam logic [31:0] EXT_PORT2     = 32'h8000_0850;
   localparam logic [31:0] CFG_ADDR_RST  = 32'h0000_0000;
   localparam int          MAP_BIT_POS   = 16;
   localparam int          IOC_BIT_POS   = 17;
   localparam logic [7:0]  CONF1_OFFSET  = 8'hA8;
   localparam logic [31:0] CONF1_RST     = 32'hFF00_0010;
   localparam int          CFG_WORDS     = 64;
   typedef enum logic [3:0] {
      HADC_NONE, HADC_SYSMEM, HADC_PCIMEM, HADC_PCIIO, HADC_CFGADDR, HADC_CFGDATA,
      HADC_INTACK, HADC_SPECIAL, HADC_INTREG, HADC_ROM, HADC_RSVD
   } hadc_region_t;
endpackage
`default_nettype wire

// ### logic/hadc_cfg_mem.sv
`timescale 1ns/10ps
`default_nettype none
module hadc_cfg_mem #(
   parameter int WORDS = 64
) (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     we,
   input  wire logic [3:0]               be,
   input  wire logic [$clog2(WORDS)-1:0] addr,
   input  wire logic [31:0]              wdata,
   output logic      [31:0]              rdata
);
   // Refuse a depth the word index cannot address
   if (WORDS < 2) begin : g_words_chk
      $error("WORDS too small");
   end
   logic [31:0] mem_q [WORDS];
   logic [31:0] wr_d;
   logic [31:0] rd_d;
   always_comb begin
      wr_d = mem_q[addr];
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            wr_d[8*i +: 8] = wdata[8*i +: 8];
         end
      end
      rd_d = mem_q[addr];
   end
   // Memory array has no reset; contents undefined until written
   always_ff @(posedge clk) begin
      if (we) begin
         mem_q[addr] <= wr_d;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= rd_d;
      end
   end
endmodule
`default_nettype wire

// ### logic/hadc_top.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Flat map passes processor addresses to PCI unchanged, except indirect config.
// - Flat map: addresses below 2G are local memory, no PCI cycle.
// - Flat map: claim every PCI cycle below 2G with DEVSEL.
// - Flat map: upper regions forwarded as PCI memory or PCI I/O per ranges.
// - Flat map config-address and config-data port ranges generate PCI config cycles.
// - Reads in special/intack range run PCI interrupt-acknowledge.
// - Writes in special/intack range run PCI special cycle.
// - Flat map: internal registers in 256-byte window, low byte is offset.
// - Flat map: top 16M is ROM space.
// - Translated map: write config address word, bridge latches it.
// - Data location then reads or writes the selected internal register.
// - Data-port byte position adds to latched aligned offset.
// - Internal registers little-endian, byte n lowest order.
// - Selected config bits also visible at three fixed addresses.
// - Strap sampled at reset picks map; state readable in config bit.
// - Config bit selects contiguous or discontiguous indirect locations.
module hadc_top #(
   parameter int CFG_WORDS = hadc_pkg::CFG_WORDS
) (
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   input  wire logic        MAP_SELECT_STRAP,
   input  wire logic        CPU_REQ,
   input  wire logic        CPU_WR,
   input  wire logic [31:0] CPU_ADDR,
   input  wire logic [3:0]  CPU_BE,
   input  wire logic [31:0] CPU_WDATA,
   input  wire logic        PCI_TGT_VALID,
   input  wire logic [31:0] PCI_TGT_ADDR,
   output logic             CPU_ACK,
   output logic [31:0]      CPU_RDATA,
   output logic [3:0]       CPU_REGION,
   output logic             PCI_REQ,
   output logic [31:0]      PCI_ADDR,
   output logic             PCI_WR,
   output logic [3:0]       PCI_BE,
   output logic [31:0]      PCI_WDATA,
   output logic [3:0]       PCI_KIND,
   output logic             PCI_DEVSEL,
   output logic             MAP_TRANSLATED
);
   // Offsets and the fixed-port alias assume a 256-byte space
   if (CFG_WORDS != 64) begin : g_cfg_words_chk
      $error("CFG_WORDS must be 64");
   end
   localparam int AW = $clog2(CFG_WORDS);

   logic       strap_s1_q, strap_s2_q;
   logic       strap_v1_q, strap_v2_q;
   logic       rd_c1_q, rd_c1_d;
   logic       map_tr_q, map_tr_d;
   logic       strap_done_q, strap_done_d;
   logic [31:0] caddr_q, caddr_d;
   logic       ioc_q, ioc_d;
   logic       rd_pend_q, rd_pend_d;
   logic       rd_cfg_q, rd_cfg_d;
   logic       ack_d;
   logic [31:0] rdata_d;
   hadc_pkg::hadc_region_t reg_d;
   logic       preq_d, pwr_d, devsel_d;
   logic [31:0] paddr_d, pwdata_d;
   logic [3:0] pbe_d;
   hadc_pkg::hadc_region_t pkind_d;
   logic [31:0] rdata_q;
   logic [31:0] mem_rdata;
   logic        mem_we;
   logic [AW-1:0] mem_addr;
   logic [31:0] a;
   logic        is_idx_addr, is_idx_data, is_ext, is_win;

   // Strap passes two flops before use
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         strap_s1_q <= 1'b0;
         strap_s2_q <= 1'b0;
         strap_v1_q <= 1'b0;
         strap_v2_q <= 1'b0;
      end else begin
         strap_s1_q <= MAP_SELECT_STRAP;
         strap_s2_q <= strap_s1_q;
         strap_v1_q <= 1'b1;
         strap_v2_q <= strap_v1_q;
      end
   end

   hadc_cfg_mem #(.WORDS(CFG_WORDS)) u_mem (
      .clk   (SYS_CLK),
      .rst_n (RST_N),
      .we    (mem_we),
      .be    (CPU_BE),
      .addr  (mem_addr),
      .wdata (CPU_WDATA),
      .rdata (mem_rdata)
   );

   always_comb begin
      a = CPU_ADDR;
      map_tr_d = map_tr_q;
      strap_done_d = strap_done_q || strap_v2_q;
      // Wait until the synchroniser holds a pin value, not its reset zero
      if (strap_v2_q && !strap_done_q) begin
         map_tr_d = strap_s2_q;
      end
      caddr_d = caddr_q;
      ioc_d = ioc_q;
      rd_pend_d = 1'b0;
      rd_cfg_d = 1'b0;
      rd_c1_d = 1'b0;
      ack_d = 1'b0;
      rdata_d = 32'h0000_0000;
      reg_d = hadc_pkg::HADC_NONE;
      preq_d = 1'b0;
      pwr_d = CPU_WR;
      paddr_d = a;
      pbe_d = CPU_BE;
      pwdata_d = CPU_WDATA;
      pkind_d = hadc_pkg::HADC_NONE;
      mem_we = 1'b0;
      mem_addr = a[AW+1:2];
      is_idx_addr = ioc_q ? (a == hadc_pkg::IDX_ADDR_DISC) : (a == hadc_pkg::IDX_ADDR_CONT);
      is_idx_data = ioc_q ? (a[31:2] == hadc_pkg::IDX_DATA_DISC[31:2])
                          : (a[31:2] == hadc_pkg::IDX_DATA_CONT[31:2]);
      is_ext = (a[31:2] == hadc_pkg::EXT_PORT0[31:2]) || (a[31:2] == hadc_pkg::EXT_PORT1[31:2])
            || (a[31:2] == hadc_pkg::EXT_PORT2[31:2]);
      is_win = (a >= hadc_pkg::WIN_LO) && (a <= hadc_pkg::WIN_HI);
      // Pending read returns the registered memory word, or the latched config address, one cycle later
      if (rd_pend_q) begin
         ack_d = 1'b1;
         rdata_d = rd_cfg_q ? mem_rdata : caddr_q;
         // Read-only map status overrides whatever was stored there
         if (rd_c1_q) begin
            rdata_d[hadc_pkg::MAP_BIT_POS] = map_tr_q;
         end
      end
      if (CPU_REQ && !rd_pend_q) begin
         if (map_tr_q) begin
            if (is_idx_addr) begin
               reg_d = hadc_pkg::HADC_CFGADDR;
               if (CPU_WR) begin
                  caddr_d = CPU_WDATA;
                  ack_d = 1'b1;
               end else begin
                  rd_pend_d = 1'b1;
               end
            end else if (is_idx_data) begin
               reg_d = hadc_pkg::HADC_INTREG;
               // Byte lanes select bytes above the aligned latched offset
               mem_addr = caddr_q[AW+1:2];
               mem_we = CPU_WR;
               ack_d = CPU_WR;
               rd_pend_d = !CPU_WR;
               rd_cfg_d = 1'b1;
            end else if (is_ext) begin
               // Fixed ports alias the first processor-interface word
               reg_d = hadc_pkg::HADC_INTREG;
               mem_addr = hadc_pkg::CONF1_OFFSET[AW+1:2];
               mem_we = CPU_WR;
               ack_d = CPU_WR;
               rd_pend_d = !CPU_WR;
               rd_cfg_d = 1'b1;
            end else begin
               // Translated region table lives elsewhere; tag as memory and ack without a PCI request
               reg_d = (a < hadc_pkg::MEM_LIMIT) ? hadc_pkg::HADC_SYSMEM : hadc_pkg::HADC_PCIMEM;
               ack_d = 1'b1;
            end
         end else begin
            if (a < hadc_pkg::MEM_LIMIT) reg_d = hadc_pkg::HADC_SYSMEM;
            else if (a < hadc_pkg::PIO1_LO) reg_d = hadc_pkg::HADC_PCIMEM;
            else if (a < hadc_pkg::CADDR_LO) reg_d = hadc_pkg::HADC_PCIIO;
            else if (a < hadc_pkg::CDATA_LO) reg_d = hadc_pkg::HADC_CFGADDR;
            else if (a < hadc_pkg::SPEC_LO) reg_d = hadc_pkg::HADC_CFGDATA;
            else if (a < hadc_pkg::PMEM2_LO)
               reg_d = CPU_WR ? hadc_pkg::HADC_SPECIAL : hadc_pkg::HADC_INTACK;
            else if (a < hadc_pkg::RSV_LO) reg_d = hadc_pkg::HADC_PCIMEM;
            else if (a < hadc_pkg::PIO2_LO) reg_d = hadc_pkg::HADC_RSVD;
            else if (is_win) reg_d = hadc_pkg::HADC_INTREG;
            else if (a < hadc_pkg::PMEM3_LO) reg_d = hadc_pkg::HADC_PCIIO;
            else if (a < hadc_pkg::ROM_LO) reg_d = hadc_pkg::HADC_PCIMEM;
            else reg_d = hadc_pkg::HADC_ROM;
            if (reg_d == hadc_pkg::HADC_INTREG) begin
               mem_we = CPU_WR;
               ack_d = CPU_WR;
               rd_pend_d = !CPU_WR;
               rd_cfg_d = 1'b1;
            end else begin
               ack_d = 1'b1;
               preq_d = (reg_d != hadc_pkg::HADC_SYSMEM) && (reg_d != hadc_pkg::HADC_ROM)
                     && (reg_d != hadc_pkg::HADC_RSVD);
               pkind_d = reg_d;
            end
         end
      end
      if (mem_we && (mem_addr == hadc_pkg::CONF1_OFFSET[AW+1:2]) && CPU_BE[2]) begin
         ioc_d = CPU_WDATA[hadc_pkg::IOC_BIT_POS];
      end
      rd_c1_d = rd_pend_d && rd_cfg_d && (mem_addr == hadc_pkg::CONF1_OFFSET[AW+1:2]);
      devsel_d = PCI_TGT_VALID && !map_tr_q && (PCI_TGT_ADDR < hadc_pkg::MEM_LIMIT);
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         map_tr_q <= 1'b0;
         strap_done_q <= 1'b0;
         caddr_q <= hadc_pkg::CFG_ADDR_RST;
         ioc_q <= hadc_pkg::CONF1_RST[hadc_pkg::IOC_BIT_POS];
         rd_pend_q <= 1'b0;
         rd_cfg_q <= 1'b0;
         rd_c1_q <= 1'b0;
         CPU_ACK <= 1'b0;
         rdata_q <= 32'h0000_0000;
         CPU_REGION <= 4'h0;
         PCI_REQ <= 1'b0;
         PCI_ADDR <= 32'h0000_0000;
         PCI_WR <= 1'b0;
         PCI_BE <= 4'h0;
         PCI_WDATA <= 32'h0000_0000;
         PCI_KIND <= 4'h0;
         PCI_DEVSEL <= 1'b0;
      end else begin
         map_tr_q <= map_tr_d;
         strap_done_q <= strap_done_d;
         caddr_q <= caddr_d;
         ioc_q <= ioc_d;
         rd_pend_q <= rd_pend_d;
         rd_cfg_q <= rd_cfg_d;
         rd_c1_q <= rd_c1_d;
         CPU_ACK <= ack_d;
         rdata_q <= rdata_d;
         CPU_REGION <= reg_d;
         PCI_REQ <= preq_d;
         PCI_ADDR <= paddr_d;
         PCI_WR <= pwr_d;
         PCI_BE <= pbe_d;
         PCI_WDATA <= pwdata_d;
         PCI_KIND <= pkind_d;
         PCI_DEVSEL <= devsel_d;
      end
   end

   // Read data and map state come straight from their flops
   always_comb begin
      CPU_RDATA = rdata_q;
      MAP_TRANSLATED = map_tr_q;
   end
endmodule
`default_nettype wire

// ### sim/hadc_pci_agent.sv
`timescale 1ns/10ps
`default_nettype none
module hadc_pci_agent (
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic [31:0] addr,
   output logic             valid,
   output logic [31:0]      taddr
);
   initial begin
      valid = 1'h0;
      taddr = 32'h0;
   end
   // Released address bus flips so a stale value never looks valid
   always @(posedge clk) begin
      valid <= go;
      taddr <= go ? addr : ~taddr;
   end
endmodule
`default_nettype wire

// ### sim/hadc_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module hadc_top_asserts (
   input wire logic        SYS_CLK,
   input wire logic        RST_N,
   input wire logic        CPU_REQ,
   input wire logic        CPU_WR,
   input wire logic [31:0] CPU_ADDR,
   input wire logic        PCI_TGT_VALID,
   input wire logic [31:0] PCI_TGT_ADDR,
   input wire logic        CPU_ACK,
   input wire logic [3:0]  CPU_REGION,
   input wire logic        PCI_REQ,
   input wire logic [31:0] PCI_ADDR,
   input wire logic [3:0]  PCI_KIND,
   input wire logic        PCI_DEVSEL,
   input wire logic        MAP_TRANSLATED
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   logic rq;
   assign rq = CPU_REQ && !MAP_TRANSLATED;
   a_sysmem_local: assert property (rq && !CPU_ADDR[31] |=>
      CPU_REGION == hadc_pkg::HADC_SYSMEM && !PCI_REQ) else $error("sysmem decode");
   a_addr_passthru: assert property (PCI_REQ |-> PCI_ADDR == $past(CPU_ADDR))
      else $error("pci address altered");
   a_devsel_claim: assert property (PCI_TGT_VALID && !MAP_TRANSLATED &&
      !PCI_TGT_ADDR[31] |=> PCI_DEVSEL) else $error("devsel missing");
   a_devsel_cause: assert property (PCI_DEVSEL |->
      $past(PCI_TGT_VALID) && !$past(PCI_TGT_ADDR[31])) else $error("devsel spurious");
   a_pcimem_fwd: assert property (rq && CPU_ADDR[31:28] == 4'h8 |=>
      PCI_REQ && PCI_KIND == hadc_pkg::HADC_PCIMEM) else $error("pci memory decode");
   a_intack_read: assert property (rq && !CPU_WR && CPU_ADDR[31:21] == 11'h787 |=>
      PCI_REQ && PCI_KIND == hadc_pkg::HADC_INTACK) else $error("intack decode");
   a_special_write: assert property (rq && CPU_WR && CPU_ADDR[31:21] == 11'h787 |=>
      PCI_REQ && PCI_KIND == hadc_pkg::HADC_SPECIAL) else $error("special decode");
   a_window_local: assert property (rq && CPU_ADDR[31:8] == 24'hF8FFF0 |=>
      CPU_REGION == hadc_pkg::HADC_INTREG && !PCI_REQ) else $error("window decode");
   a_rom_local: assert property (rq && CPU_ADDR[31:24] == 8'hFF |=>
      CPU_REGION == hadc_pkg::HADC_ROM && !PCI_REQ) else $error("rom decode");
   a_ack_bound: assert property (CPU_REQ |-> ##[1:2] CPU_ACK)
      else $error("ack late");
   c_devsel: cover property (PCI_DEVSEL);
   c_special: cover property (PCI_REQ && PCI_KIND == hadc_pkg::HADC_SPECIAL);
   c_translated: cover property (CPU_ACK && MAP_TRANSLATED);
endmodule
bind hadc_top hadc_top_asserts u_hadc_top_asserts (.SYS_CLK, .RST_N, .CPU_REQ, .CPU_WR,
   .CPU_ADDR, .PCI_TGT_VALID, .PCI_TGT_ADDR, .CPU_ACK, .CPU_REGION, .PCI_REQ, .PCI_ADDR,
   .PCI_KIND, .PCI_DEVSEL, .MAP_TRANSLATED);
`default_nettype wire

// ### sim/host_address_decode_config_access_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module host_address_decode_config_access_bench;
   logic        clk = 1'h0, rst_n = 1'h0, strap = 1'h0, req = 1'h0, wr = 1'h0, go = 1'h0;
   logic [31:0] addr = 32'h0, wd = 32'h0, ga = 32'h0, ta, rd, pa, pwd, r_rd, r_pa, r_pwd;
   logic [3:0]  be = 4'h0, rg, pbe, pk, r_rg, r_pk, r_pbe;
   logic        tv, ack, preq, pwr, dsel, mt, r_pq, r_pw;
   int          num_errors = 0, checks_done = 0;
   always #4 clk = ~clk;
   hadc_top u_hadc_top (.SYS_CLK(clk), .RST_N(rst_n), .MAP_SELECT_STRAP(strap),
      .CPU_REQ(req), .CPU_WR(wr), .CPU_ADDR(addr), .CPU_BE(be), .CPU_WDATA(wd),
      .PCI_TGT_VALID(tv), .PCI_TGT_ADDR(ta), .CPU_ACK(ack), .CPU_RDATA(rd),
      .CPU_REGION(rg), .PCI_REQ(preq), .PCI_ADDR(pa), .PCI_WR(pwr), .PCI_BE(pbe),
      .PCI_WDATA(pwd), .PCI_KIND(pk), .PCI_DEVSEL(dsel), .MAP_TRANSLATED(mt));
   hadc_pci_agent u_hadc_pci_agent (.clk(clk), .go(go), .addr(ga), .valid(tv), .taddr(ta));
   // Big-endian processor lane order against the block's little-endian lanes
   function automatic logic [31:0] swap32(input logic [31:0] v);
      return {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction
   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic do_reset(input logic s);
      rst_n <= 1'h0;
      strap <= s;
      repeat (12) @(posedge clk);
      rst_n <= 1'h1;
      repeat (4) @(posedge clk);
      `CHK(mt, s)
   endtask
   // Four cycles cover a read plus its idle gap
   task automatic acc(input logic w, input logic [31:0] a, input logic [3:0] b,
                      input logic [31:0] d);
      logic got;
      got = 1'h0;
      r_rg = 4'h0;
      r_pq = 1'h0;
      r_pk = 4'h0;
      r_rd = 32'hX;
      r_pa = 32'h0;
      r_pw = 1'h0;
      r_pbe = 4'h0;
      r_pwd = 32'h0;
      @(posedge clk);
      req <= 1'h1;
      wr <= w;
      addr <= a;
      be <= b;
      wd <= d;
      @(posedge clk);
      req <= 1'h0;
      for (int i = 0; i < 4; i++) begin
         #1;
         if (rg !== 4'h0) r_rg = rg;
         if (preq === 1'h1) begin
            r_pq = 1'h1;
            r_pk = pk;
            r_pa = pa;
            r_pw = pwr;
            r_pbe = pbe;
            r_pwd = pwd;
         end
         if (ack === 1'h1) begin
            got = 1'h1;
            r_rd = rd;
         end
         @(posedge clk);
      end
      if (!got) begin
         num_errors++;
         finish_test();
      end
   endtask
   task automatic t_flat_decode;
      logic [3:0]  k;
      logic [36:0] tb [15] = '{{4'h1, 1'h1, 32'h0000_1000}, {4'h1, 1'h1, 32'h7FFF_FFFC},
         {4'h2, 1'h1, 32'h8000_0000}, {4'h2, 1'h1, 32'hEFFF_FFFC}, {4'h3, 1'h1, 32'hF000_0000},
         {4'h4, 1'h1, 32'hF080_0000}, {4'h5, 1'h1, 32'hF0C0_0000}, {4'h6, 1'h0, 32'hF0E0_0000},
         {4'h7, 1'h1, 32'hF0FF_FFFC}, {4'h2, 1'h1, 32'hF100_0000}, {4'h3, 1'h1, 32'hF8FF_EFFC},
         {4'h3, 1'h1, 32'hF8FF_F100}, {4'h2, 1'h1, 32'hF900_0000}, {4'h9, 1'h0, 32'hFF00_0000},
         {4'hA, 1'h1, 32'hF200_0000}};
      foreach (tb[i]) begin
         k = tb[i][36:33];
         acc(tb[i][32], tb[i][31:0], 4'hF, ~tb[i][31:0]);
         `CHK(r_rg, k)
         `CHK(r_pq, k != 4'h1 && k != 4'h9 && k != 4'hA)
         if (r_pq) begin
            `CHK(r_pk, k)
            `CHK(r_pa, tb[i][31:0])
            `CHK(r_pw, tb[i][32])
            `CHK(r_pbe, 4'hF)
            `CHK(r_pwd, ~tb[i][31:0])
         end
      end
   endtask
   task automatic t_window;
      acc(1'h1, 32'hF8FF_F0A8, 4'hF, 32'hFFFF_FFFF);
      acc(1'h1, 32'hF8FF_F0A8, 4'hC, 32'hAABB_CCDD);
      acc(1'h1, 32'hF8FF_F0A8, 4'h1, 32'hAABB_CCDD);
      acc(1'h0, 32'hF8FF_F0A8, 4'hF, 32'h0);
      `CHK(r_rd, 32'hAABA_FFDD)
      acc(1'h1, 32'hF8FF_F0A8, 4'hF, swap32(32'hDDCC_BBAA));
      acc(1'h0, 32'hF8FF_F0A8, 4'hF, 32'h0);
      `CHK(r_rd, 32'hAABA_CCDD)
   endtask
   task automatic t_devsel;
      logic [31:0] al [3] = '{32'h0000_0000, 32'h7FFF_FFFC, 32'h8000_0000};
      foreach (al[i]) begin
         @(posedge clk);
         go <= 1'h1;
         ga <= al[i];
         @(posedge clk);
         go <= 1'h0;
         @(posedge clk);
         #1;
         `CHK(dsel, ~al[i][31])
      end
   endtask
   task automatic t_translated;
      @(posedge clk);
      do_reset(1'h1);
      acc(1'h1, 32'h8000_0CF8, 4'hF, 32'h8000_00A8);
      acc(1'h0, 32'h8000_0CF8, 4'hF, 32'h0);
      `CHK(r_rd, 32'h8000_00A8)
      acc(1'h1, 32'h8000_0CFC, 4'hF, 32'h1234_5678);
      acc(1'h0, 32'h8000_0CFC, 4'hF, 32'h0);
      `CHK(r_rd, 32'h1235_5678)
      acc(1'h1, 32'h8000_0CFE, 4'hC, 32'hCCDD_0000);
      acc(1'h0, 32'h8000_0092, 4'hF, 32'h0);
      `CHK(r_rd, 32'hCCDD_5678)
      acc(1'h1, 32'h8000_0CFC, 4'hF, 32'h0002_0000);
      // Software-swapped address, lanes reversed by a big-endian processor
      acc(1'h1, 32'h8006_7018, 4'hF, swap32(32'hA800_0080));
      acc(1'h0, 32'h8006_701C, 4'hF, 32'h0);
      `CHK(r_rd, 32'h0003_0000)
      acc(1'h1, 32'h8006_701C, 4'hF, r_rd & 32'hFFFD_FFFF);
      acc(1'h0, 32'h8000_0CF8, 4'hF, 32'h0);
      `CHK(r_rd, 32'h8000_00A8)
   endtask
   initial begin
      do_reset(1'h0);
      t_flat_decode();
      t_window();
      t_devsel();
      t_translated();
      finish_test();
   end
endmodule
`default_nettype wire
